/* design/gcb_map.vh */
// constants for the pin control and correction busy register bank
// What this block does
// - write top bit: one releases, zero pulls low
// - read returns synchronised live pin level
// - all resets leave pin register at 8000h
// - unused bits ignore writes, read zero
// - busy register read-only, channel 7 at bit 15
// - data, offset, gain write sets busy
// - busy clears when corrected result lands
// - one channel correction takes about 500 ns
// - engine off forces all busy flags zero
`ifndef GCB_MAP_VH
`define GCB_MAP_VH

// register indices on the parallel register port
`define GCB_ADDR_W 5
`define GCB_IDX_PIN_CTRL 5'h0a
`define GCB_IDX_BUSY 5'h0b

// field positions
`define GCB_PIN_BIT 15
`define GCB_BUSY_LSB 8
`define GCB_BUSY_MSB 15

// reset values
`define GCB_PIN_CTRL_RST 16'h8000
`define GCB_BUSY_RST 16'h0000
`define GCB_BUSY_FLAGS_RST 8'h00

// correction timing
`define GCB_CLK_PERIOD_NS 50
`define GCB_CORR_TIME_NS 500
`define GCB_CORR_CYCLES (`GCB_CORR_TIME_NS / `GCB_CLK_PERIOD_NS)
`define GCB_CNT_W 4
`define GCB_CORR_LAST 4'h9

// channel count
`define GCB_NCH 8

`endif

/* design/gcb_pin_sync.v */
// two-stage synchroniser for the general pin input
`timescale 1ns/1ps
`default_nettype none
module gcb_pin_sync
(
    // clock and reset
    input wire clk,
    input wire reset,
    // pin level in and out
    input wire pin_async,
    output reg pin_sync
);

reg meta_q;

always @(posedge clk)
begin
    if (reset)
    begin
        meta_q <= 1'b1;
        pin_sync <= 1'b1;
    end
    else
    begin
        meta_q <= pin_async;
        pin_sync <= meta_q;
    end
end

endmodule
`default_nettype wire

/* design/gcb_corr_engine.v */
// correction engine sequencer: serves pending channels one at a time
`timescale 1ns/1ps
`default_nettype none
`include "gcb_map.vh"
module gcb_corr_engine
(
    // clock and reset
    input wire clk,
    input wire reset,
    // control
    input wire engine_en,
    input wire [`GCB_NCH-1:0] pending,
    // completion
    output reg done_valid,
    output reg [2:0] done_chan,
    output reg active
);

localparam [`GCB_CNT_W-1:0] CORR_LAST = `GCB_CORR_LAST;

reg [`GCB_CNT_W-1:0] cnt_q;
reg [2:0] chan_q;

// lowest pending channel wins
function [2:0] pick_low;
    input [`GCB_NCH-1:0] req;
    integer i;
    begin
        pick_low = 3'h0;
        for (i = `GCB_NCH - 1; i >= 0; i = i - 1)
        begin
            if (req[i])
                pick_low = i[2:0];
        end
    end
endfunction

always @(posedge clk)
begin
    if (reset || !engine_en)
    begin
        cnt_q <= 4'h0;
        chan_q <= 3'h0;
        active <= 1'b0;
        done_valid <= 1'b0;
        done_chan <= 3'h0;
    end
    else
    begin
        done_valid <= 1'b0;
        if (!active)
        begin
            if (|pending)
            begin
                active <= 1'b1;
                chan_q <= pick_low(pending);
                cnt_q <= 4'h0;
            end
        end
        else if (cnt_q == CORR_LAST)
        begin
            // result moved to channel data register
            active <= 1'b0;
            done_valid <= 1'b1;
            done_chan <= chan_q;
        end
        else
        begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
end

endmodule
`default_nettype wire

/* design/gcb_regs.v */
// pin control register and per-channel correction busy flags
`timescale 1ns/1ps
`default_nettype none
`include "gcb_map.vh"
module gcb_regs
(
    // clock and reset (power-on, hardware and software resets combined)
    input wire clk,
    input wire reset,
    // parallel register port
    input wire [`GCB_ADDR_W-1:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    // correction engine control and data-path write events
    input wire engine_en,
    input wire [`GCB_NCH-1:0] chan_write,
    // general pin, open drain
    input wire gpin_in,
    output wire gpin_out,
    output wire gpin_oe
);

// =====================================================
// index decoding
function is_pin_idx;
    input [`GCB_ADDR_W-1:0] addr;
    begin
        is_pin_idx = (addr == `GCB_IDX_PIN_CTRL);
    end
endfunction

function is_busy_idx;
    input [`GCB_ADDR_W-1:0] addr;
    begin
        is_busy_idx = (addr == `GCB_IDX_BUSY);
    end
endfunction

// =====================================================
// pin control
reg pin_q;
wire pin_level;
wire pin_wr;

// writes to the busy index fall through: register is read-only
assign pin_wr = reg_wr && is_pin_idx(reg_addr);

always @(posedge clk)
begin
    if (reset)
        pin_q <= 1'b1;
    else if (pin_wr)
        pin_q <= reg_wdata[`GCB_PIN_BIT];
end

// drive low only when stored bit is zero
assign gpin_out = 1'b0;
assign gpin_oe = ~pin_q;

gcb_pin_sync u_sync
(
    .clk(clk),
    .reset(reset),
    .pin_async(gpin_in),
    .pin_sync(pin_level)
);

// =====================================================
// busy flags
reg [`GCB_NCH-1:0] busy_q;
wire done_valid;
wire [2:0] done_chan;
reg [`GCB_NCH-1:0] done_vec;
wire [`GCB_NCH-1:0] eng_pending;

// hide a channel whose completion is still landing, so it is not served twice
assign eng_pending = busy_q & ~done_vec;

always @*
begin
    done_vec = {`GCB_NCH{1'b0}};
    if (done_valid)
        done_vec[done_chan] = 1'b1;
end

gcb_corr_engine u_eng
(
    .clk(clk),
    .reset(reset),
    .engine_en(engine_en),
    .pending(eng_pending),
    .done_valid(done_valid),
    .done_chan(done_chan),
    .active()
);

always @(posedge clk)
begin
    if (reset || !engine_en)
        busy_q <= `GCB_BUSY_FLAGS_RST;
    else
        // a new write wins over a completion in the same cycle
        busy_q <= (busy_q & ~done_vec) | chan_write;
end

// =====================================================
// read data, registered
always @(posedge clk)
begin
    if (reset)
        reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
        if (is_pin_idx(reg_addr))
            reg_rdata <= {pin_level, 15'h0000};
        else if (is_busy_idx(reg_addr))
            reg_rdata <= {busy_q, 8'h00};
        else
            reg_rdata <= 16'h0000;
    end
end

endmodule
`default_nettype wire

/* testbench/gcb_regs_asserts.sv */
// port checks for the register bank
`timescale 1ns/1ps
`default_nettype none
module gcb_regs_asserts
(
    // register port, engine and pin
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic engine_en,
    input wire logic [7:0] chan_write,
    input wire logic gpin_in,
    input wire logic gpin_out,
    input wire logic gpin_oe
);
default clocking @(posedge clk); endclocking
default disable iff (reset);
wire logic pw = reg_wr && reg_addr == 5'h0a;
wire logic rb = reg_rd && reg_addr == 5'h0b;
pin_wr_a: assert property (pw |=> gpin_oe != $past(reg_wdata[15])) else $error("pin");
oe_src_a: assert property ($changed(gpin_oe) |-> $past(pw)) else $error("oe");
out_lo_a: assert property (gpin_oe |-> !gpin_out) else $error("out");
rst_pin_a: assert property ($fell(reset) |-> !gpin_oe) else $error("rst");
pin_rd_a: assert property (reg_rd && reg_addr == 5'h0a |=> reg_rdata == {$past(gpin_in, 3), 15'h0}) else $error("rd");
busy_lsb_a: assert property (rb |=> reg_rdata[7:0] == 0) else $error("lsb");
busy_set_a: assert property (chan_write != 0 && engine_en ##1 rb && engine_en
    |=> (reg_rdata[15:8] & $past(chan_write, 2)) == $past(chan_write, 2)) else $error("set");
busy_off_a: assert property (!engine_en && !$past(engine_en) && rb |=> reg_rdata == 0) else $error("off");
cover property (pw);
cover property (rb && engine_en);
cover property ($fell(gpin_oe));
endmodule
bind gcb_regs gcb_regs_asserts gcb_regs_asserts_inst (.*);
`default_nettype wire

/* testbench/gcb_pin_board.sv */
// board side of the general pin: pull-up and an outside driver
`timescale 1ns/1ps
`default_nettype none
module gcb_pin_board
(
    // pin
    input wire logic gpin_out,
    input wire logic gpin_oe,
    input wire logic ext_low,
    output wire logic gpin_in
);
// pull-up wins unless someone drives low
assign gpin_in = gpin_oe ? gpin_out : !ext_low;
endmodule
`default_nettype wire

/* testbench/gcb_regs_tb_top.sv */
// bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module gcb_regs_tb_top;
logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, engine_en = 0, ext_low = 0;
logic [4:0] reg_addr = 0;
logic [15:0] reg_wdata = 0;
logic [7:0] chan_write = 0;
wire logic [15:0] reg_rdata;
wire logic gpin_in, gpin_out, gpin_oe;
int errors = 0, check_count = 0, cyc = 0;
gcb_regs gcb_regs_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .engine_en(engine_en), .chan_write(chan_write),
    .gpin_in(gpin_in), .gpin_out(gpin_out), .gpin_oe(gpin_oe));
gcb_pin_board gcb_pin_board_inst (.gpin_out(gpin_out), .gpin_oe(gpin_oe), .ext_low(ext_low), .gpin_in(gpin_in));
initial forever #25 clk = ~clk;
always @(posedge clk)
    if (++cyc == 400)
        final_report;
// one register access; reads are compared
task acc(input logic w, input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    chan_write <= 0;
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 0;
    #1 check_count += !w;
    if (!w && reg_rdata !== v)
    begin
        errors++;
        $display("ERROR reg_rdata exp %h got %h", v, reg_rdata);
    end
endtask
task t_pin;
    acc(0, 5'h0a, 16'h8000);
    acc(1, 5'h0a, 16'h7fff);
    acc(0, 5'h1f, 16'h0000);
    acc(0, 5'h0a, 16'h0000);
    acc(1, 5'h0a, 16'hffff);
    ext_low <= 1;
    acc(0, 5'h0b, 16'h0000);
    acc(0, 5'h0a, 16'h0000);
    ext_low <= 0;
endtask
task t_busy;
    @(posedge clk);
    engine_en <= 1;
    chan_write <= 8'h81;
    acc(0, 5'h0b, 16'h8100);
    repeat (12) @(posedge clk);
    acc(0, 5'h0b, 16'h8000);
    repeat (12) @(posedge clk);
    acc(1, 5'h0b, 16'hffff);
    acc(0, 5'h0b, 16'h0000);
    @(posedge clk);
    chan_write <= 8'h10;
    @(posedge clk);
    chan_write <= 0;
    engine_en <= 0;
    acc(0, 5'h0b, 16'h0000);
    repeat (2) @(posedge clk);
endtask
task final_report;
    errors += cyc >= 400;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
initial
begin
    repeat (16) @(posedge clk);
    reset <= 0;
    t_pin;
    t_busy;
    final_report;
end
endmodule
`default_nettype wire
